// >>> logic/pbcfs_pkg.sv
/*
  pbcfs_pkg: register offsets, reset values, field positions and
  selection codes of the port B / port C function select block.
  Assumes a 32-bit APB register bus, one register per aligned word.
*/
package pbcfs_pkg;

  // register byte offsets
  localparam logic [7:0] PBCFS_OFS_PB_LOW   = 8'h00;
  localparam logic [7:0] PBCFS_OFS_PB_HIGH  = 8'h04;
  localparam logic [7:0] PBCFS_OFS_PC_LOW   = 8'h08;
  localparam logic [7:0] PBCFS_OFS_PC_HIGH  = 8'h0C;
  localparam logic [7:0] PBCFS_OFS_IN_SEL   = 8'h10;

  // reset values
  localparam logic [7:0] PBCFS_RST_SELECT   = 8'h00;
  localparam logic [1:0] PBCFS_RST_RX_PIN   = 2'h0;

  // implemented bits of the input function select register
  localparam logic [7:0] PBCFS_IN_SEL_MASK  = 8'h03;

  // field low bit positions inside a select register
  localparam int PBCFS_FLD_PIN0 = 0;
  localparam int PBCFS_FLD_PIN1 = 2;
  localparam int PBCFS_FLD_PIN2 = 4;
  localparam int PBCFS_FLD_PIN3 = 6;

  // two-bit selection codes
  typedef enum logic [1:0] {
    PBCFS_SEL_00 = 2'b00,
    PBCFS_SEL_01 = 2'b01,
    PBCFS_SEL_10 = 2'b10,
    PBCFS_SEL_11 = 2'b11
  } pbcfs_sel_t;

endpackage

// >>> logic/pbcfs_pin_cell.sv
/*
  pbcfs_pin_cell: one pin output driver mux between the port latch
  path and a peripheral output path.
  Assumes the select input is a decode of the registered field.
*/
`timescale 1ns/1ps
module pbcfs_pin_cell (
  input  wire logic periph_sel,
  input  wire logic latch_out,
  input  wire logic dir_input,
  input  wire logic periph_out,
  input  wire logic periph_oe,
  output logic      pin_out,
  output logic      pin_oe
);

  // peripheral drives pin when selected, else latch and direction
  assign pin_out = periph_sel ? periph_out : latch_out;
  assign pin_oe  = periph_sel ? periph_oe  : ~dir_input;

endmodule

// >>> logic/pbcfs_top.sv
/*
  pbcfs_top: pin function select for port B and port C, plus the
  uart receive source select, behind an APB slave.
  Assumes the port latches, direction bits and peripherals live
  outside; analog routing is shown as per-pin enable levels.
*/
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pbcfs_top
  import pbcfs_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // port latches and direction (1 = input) for port b and c
  input  wire logic [7:0]            port_b_latch,
  input  wire logic [7:0]            port_b_dir_input,
  input  wire logic [7:0]            port_c_latch,
  input  wire logic [7:0]            port_c_dir_input,
  // port pin levels read back
  input  wire logic                  port_a_bit0_in,
  input  wire logic [7:0]            port_b_in,
  input  wire logic [7:0]            port_c_in,
  // peripheral outputs and their enables
  input  wire logic                  periodic_timer_output,
  input  wire logic                  standard_timer1_output,
  input  wire logic                  opamp1_output,
  input  wire logic                  uart_tx,
  input  wire logic                  uart_tx_oe,
  input  wire logic                  uart_halfduplex_out,
  input  wire logic                  uart_halfduplex_oe,
  input  wire logic [3:0]            lcd_common_drive,
  input  wire logic [3:0]            lcd_common_oe,
  // pin drivers
  output logic      [7:0]            port_b_out,
  output logic      [7:0]            port_b_oe,
  output logic      [7:0]            port_c_out,
  output logic      [7:0]            port_c_oe,
  // digital inputs routed to peripherals
  output logic                       standard_timer1_clock_input,
  output logic                       external_irq1,
  output logic                       periodic_timer_clock_input,
  output logic                       periodic_timer_capture_input,
  output logic                       low_voltage_detect_input,
  output logic                       uart_rx_in,
  // analog and special pad switch enables
  output logic      [7:1]            analog_channel_en,
  output logic                       opamp1_neg_input_en,
  output logic                       io_supply_pin_en,
  output logic                       crystal_in_en,
  output logic                       crystal_out_en
);

  ////////////////////////////////////////////////////////////////
  // parameter check, refused at elaboration; the decode needs the
  // word index bits 4:2 and never looks above bit 7
  if (ADDR_WIDTH < 5 || ADDR_WIDTH > 8) begin : g_bad_addr_width
    $error("pbcfs_top: ADDR_WIDTH must lie in 5..8");
  end

  ////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] port_b_low_select;
  logic [7:0] port_b_high_select;
  logic [7:0] port_c_low_select;
  logic [7:0] port_c_high_select;
  logic [1:0] uart_receive_pin_choice;

  logic [7:0] addr8;
  logic       wr_en;
  logic       rd_hit;

  // field extraction shared by all decodes
  function automatic pbcfs_sel_t fld(input logic [7:0] r, input int pos);
    fld = pbcfs_sel_t'(r[pos +: 2]);
  endfunction

  // offset match against the word-aligned address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  assign addr8 = 8'(paddr);
  assign wr_en = psel & penable & pwrite & pstrb[0];

  ////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped access flags pslverr
  assign pready = 1'b1;

  always_comb begin
    rd_hit = 1'b1;
    if (hit(addr8, PBCFS_OFS_PB_LOW)) begin
      rd_hit = 1'b1;
    end else if (hit(addr8, PBCFS_OFS_PB_HIGH)) begin
      rd_hit = 1'b1;
    end else if (hit(addr8, PBCFS_OFS_PC_LOW)) begin
      rd_hit = 1'b1;
    end else if (hit(addr8, PBCFS_OFS_PC_HIGH)) begin
      rd_hit = 1'b1;
    end else if (hit(addr8, PBCFS_OFS_IN_SEL)) begin
      rd_hit = 1'b1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~rd_hit;

  // read data is taken at the setup edge so that it stands through
  // the whole access cycle with no wait state
  // read data, registered at the setup cycle of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit(addr8, PBCFS_OFS_PB_LOW)) begin
        prdata <= {24'h00_0000, port_b_low_select};
      end else if (hit(addr8, PBCFS_OFS_PB_HIGH)) begin
        prdata <= {24'h00_0000, port_b_high_select};
      end else if (hit(addr8, PBCFS_OFS_PC_LOW)) begin
        prdata <= {24'h00_0000, port_c_low_select};
      end else if (hit(addr8, PBCFS_OFS_PC_HIGH)) begin
        prdata <= {24'h00_0000, port_c_high_select};
      end else if (hit(addr8, PBCFS_OFS_IN_SEL)) begin
        prdata <= {30'h0000_0000, uart_receive_pin_choice};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // register writes, reset to general io
  // a write with byte strobe 0 clear leaves every field untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_low_select       <= PBCFS_RST_SELECT;
      port_b_high_select      <= PBCFS_RST_SELECT;
      port_c_low_select       <= PBCFS_RST_SELECT;
      port_c_high_select      <= PBCFS_RST_SELECT;
      uart_receive_pin_choice <= PBCFS_RST_RX_PIN;
    end else if (wr_en) begin
      if (hit(addr8, PBCFS_OFS_PB_LOW)) begin
        port_b_low_select <= pwdata[7:0];
      end else if (hit(addr8, PBCFS_OFS_PB_HIGH)) begin
        port_b_high_select <= pwdata[7:0];
      end else if (hit(addr8, PBCFS_OFS_PC_LOW)) begin
        port_c_low_select <= pwdata[7:0];
      end else if (hit(addr8, PBCFS_OFS_PC_HIGH)) begin
        port_c_high_select <= pwdata[7:0];
      end else if (hit(addr8, PBCFS_OFS_IN_SEL)) begin
        uart_receive_pin_choice <= pwdata[1:0] & PBCFS_IN_SEL_MASK[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // field decode of each pin
  // each pin's two-bit code, picked out of its select register
  pbcfs_sel_t sb0, sb1, sb2, sb3, sb4, sb5, sb6, sb7;
  pbcfs_sel_t sc0, sc1, sc2, sc3, sc4, sc5, sc6, sc7;

  assign sb0 = fld(port_b_low_select,  PBCFS_FLD_PIN0);
  assign sb1 = fld(port_b_low_select,  PBCFS_FLD_PIN1);
  assign sb2 = fld(port_b_low_select,  PBCFS_FLD_PIN2);
  assign sb3 = fld(port_b_low_select,  PBCFS_FLD_PIN3);
  assign sb4 = fld(port_b_high_select, PBCFS_FLD_PIN0);
  assign sb5 = fld(port_b_high_select, PBCFS_FLD_PIN1);
  assign sb6 = fld(port_b_high_select, PBCFS_FLD_PIN2);
  assign sb7 = fld(port_b_high_select, PBCFS_FLD_PIN3);
  assign sc0 = fld(port_c_low_select,  PBCFS_FLD_PIN0);
  assign sc1 = fld(port_c_low_select,  PBCFS_FLD_PIN1);
  assign sc2 = fld(port_c_low_select,  PBCFS_FLD_PIN2);
  assign sc3 = fld(port_c_low_select,  PBCFS_FLD_PIN3);
  assign sc4 = fld(port_c_high_select, PBCFS_FLD_PIN0);
  assign sc5 = fld(port_c_high_select, PBCFS_FLD_PIN1);
  assign sc6 = fld(port_c_high_select, PBCFS_FLD_PIN2);
  assign sc7 = fld(port_c_high_select, PBCFS_FLD_PIN3);

  ////////////////////////////////////////////////////////////////
  // peripheral select, data and enable per pin
  logic [7:0] b_psel, b_pout, b_poe;
  logic [7:0] c_psel, c_pout, c_poe;

  // port b: digital outputs only on timer and opamp codes
  // inverted timer outputs are formed here, not in the timers
  always_comb begin
    b_psel = 8'h00;
    b_pout = 8'h00;
    b_poe  = 8'h00;
    b_psel[0] = (sb0 == PBCFS_SEL_01);
    b_pout[0] = opamp1_output;
    b_psel[1] = (sb1 == PBCFS_SEL_01);
    b_pout[1] = ~standard_timer1_output;
    b_psel[3] = (sb3 == PBCFS_SEL_10);
    b_pout[3] = ~periodic_timer_output;
    b_psel[5] = (sb5 == PBCFS_SEL_01);
    b_pout[5] = periodic_timer_output;
    // analog or supply codes disconnect the digital driver
    b_psel[2] = (sb2 == PBCFS_SEL_01) || (sb2 == PBCFS_SEL_10);
    b_psel[4] = (sb4 == PBCFS_SEL_01) || (sb4 == PBCFS_SEL_10);
    b_psel[6] = (sb6 == PBCFS_SEL_01);
    b_psel[7] = (sb7 == PBCFS_SEL_01);
    b_psel[0] = b_psel[0] || (sb0 == PBCFS_SEL_10);
    b_psel[1] = b_psel[1] || (sb1 == PBCFS_SEL_10) || (sb1 == PBCFS_SEL_11);
    b_psel[3] = b_psel[3] || (sb3 == PBCFS_SEL_01);
    b_psel[5] = b_psel[5] || (sb5 == PBCFS_SEL_10) || (sb5 == PBCFS_SEL_11);
    b_poe[0] = (sb0 == PBCFS_SEL_01);
    b_poe[1] = (sb1 == PBCFS_SEL_01);
    b_poe[3] = (sb3 == PBCFS_SEL_10);
    b_poe[5] = (sb5 == PBCFS_SEL_01);
  end

  // port c: uart and lcd common functions on code 01
  always_comb begin
    c_psel = 8'h00;
    c_pout = 8'h00;
    c_poe  = 8'h00;
    c_psel[0] = (sc0 == PBCFS_SEL_01);
    c_pout[0] = lcd_common_drive[2];
    c_poe[0]  = lcd_common_oe[2];
    c_psel[1] = (sc1 == PBCFS_SEL_01);
    c_pout[1] = lcd_common_drive[1];
    c_poe[1]  = lcd_common_oe[1];
    c_psel[2] = (sc2 == PBCFS_SEL_01);
    c_pout[2] = uart_tx;
    c_poe[2]  = uart_tx_oe;
    c_psel[3] = (sc3 == PBCFS_SEL_01);
    c_pout[3] = uart_halfduplex_out;
    c_poe[3]  = uart_halfduplex_oe;
    c_psel[4] = (sc4 == PBCFS_SEL_01);
    c_pout[4] = uart_tx;
    c_poe[4]  = uart_tx_oe;
    c_psel[5] = (sc5 == PBCFS_SEL_01);
    c_pout[5] = uart_halfduplex_out;
    c_poe[5]  = uart_halfduplex_oe;
    c_psel[6] = (sc6 == PBCFS_SEL_01);
    c_pout[6] = lcd_common_drive[0];
    c_poe[6]  = lcd_common_oe[0];
    c_psel[7] = (sc7 == PBCFS_SEL_01);
    c_pout[7] = lcd_common_drive[3];
    c_poe[7]  = lcd_common_oe[3];
  end

  ////////////////////////////////////////////////////////////////
  // pin driver cells
  // one cell per pin keeps the latch or peripheral choice in one place
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pins
      pbcfs_pin_cell u_b (
        .periph_sel (b_psel[gi]),
        .latch_out  (port_b_latch[gi]),
        .dir_input  (port_b_dir_input[gi]),
        .periph_out (b_pout[gi]),
        .periph_oe  (b_poe[gi]),
        .pin_out    (port_b_out[gi]),
        .pin_oe     (port_b_oe[gi])
      );
      pbcfs_pin_cell u_c (
        .periph_sel (c_psel[gi]),
        .latch_out  (port_c_latch[gi]),
        .dir_input  (port_c_dir_input[gi]),
        .periph_out (c_pout[gi]),
        .periph_oe  (c_poe[gi]),
        .pin_out    (port_c_out[gi]),
        .pin_oe     (port_c_oe[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // digital inputs shared with general io codes, all but the low voltage detect input; software must set
  // the direction bit to input for these to see the pad
  // gated to zero so a peripheral input stays quiet while its pin
  // serves another function
  assign standard_timer1_clock_input  =
    port_b_in[3] & ((sb3 == PBCFS_SEL_00) || (sb3 == PBCFS_SEL_11));
  assign external_irq1                =
    port_b_in[1] & (sb1 == PBCFS_SEL_00);
  assign low_voltage_detect_input     =
    port_b_in[1] & (sb1 == PBCFS_SEL_11);
  assign periodic_timer_clock_input   =
    port_b_in[6] & (sb6 != PBCFS_SEL_01);
  assign periodic_timer_capture_input =
    port_b_in[5] & (sb5 == PBCFS_SEL_00);

  // uart receive source select
  // codes 10 and 11 both take port_c_bit5
  always_comb begin
    case (uart_receive_pin_choice)
      2'b00:   uart_rx_in = port_a_bit0_in;
      2'b01:   uart_rx_in = port_c_in[3];
      default: uart_rx_in = port_c_in[5];
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // analog and special pad switch enables
  // a switch closes only for its own code; the digital driver on
  // that pin has already been turned off above
  assign analog_channel_en[1] = (sb6 == PBCFS_SEL_01);
  assign analog_channel_en[2] = (sb0 == PBCFS_SEL_10);
  assign analog_channel_en[3] = (sb2 == PBCFS_SEL_10);
  assign analog_channel_en[4] = (sb3 == PBCFS_SEL_01);
  assign analog_channel_en[5] = (sb1 == PBCFS_SEL_10);
  assign analog_channel_en[6] = (sb4 == PBCFS_SEL_10);
  assign analog_channel_en[7] = (sb5 == PBCFS_SEL_11);
  assign opamp1_neg_input_en  = (sb2 == PBCFS_SEL_01);
  assign io_supply_pin_en     = (sb7 == PBCFS_SEL_01);
  assign crystal_in_en        = (sb5 == PBCFS_SEL_10);
  assign crystal_out_en       = (sb4 == PBCFS_SEL_01);

endmodule

// >>> bench/pbcfs_properties.sv
/* pbcfs_properties: port checks for pbcfs_top.
   Assumes it is bound onto pbcfs_top; APB writes seen at its ports. */
`timescale 1ns/1ps
module pbcfs_properties #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic [7:0]            port_c_latch,
  input wire logic [7:0]            port_c_dir_input,
  input wire logic [7:0]            port_b_dir_input,
  input wire logic                  port_a_bit0_in,
  input wire logic [7:0]            port_b_in,
  input wire logic [7:0]            port_c_in,
  input wire logic                  uart_tx,
  input wire logic                  uart_tx_oe,
  input wire logic [7:0]            port_b_oe,
  input wire logic [7:0]            port_c_out,
  input wire logic [7:0]            port_c_oe,
  input wire logic                  external_irq1,
  input wire logic                  uart_rx_in,
  input wire logic [7:1]            analog_channel_en,
  input wire logic                  io_supply_pin_en,
  input wire logic                  crystal_in_en,
  input wire logic                  crystal_out_en
);
  logic [7:0]           sh [5];
  wire                  wr = psel && penable && pwrite && pstrb[0];
  wire [ADDR_WIDTH-3:0] ix = paddr[ADDR_WIDTH-1:2];

  // shadow copy of the select registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) sh[i] <= 8'h00;
    end else if (wr && ix < 5) begin
      sh[ix] <= (ix == 4) ? (pwdata[7:0] & 8'h03) : pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_value:
    assert property (psel && penable && !pwrite && ix < 5 |-> prdata == {24'h0, sh[ix]})
    else $error("read data differs from written value");
  a_in_sel_zero:
    assert property (psel && penable && !pwrite && ix == 4 |-> prdata[7:2] == 6'h00)
    else $error("unused input select bits not zero");
  a_rx_source:
    assert property (uart_rx_in == (sh[4][1:0] == 2'h0 ? port_a_bit0_in :
                     sh[4][1:0] == 2'h1 ? port_c_in[3] : port_c_in[5]))
    else $error("receive source wrong");
  a_irq_gate:
    assert property (external_irq1 == (port_b_in[1] && sh[0][3:2] == 2'h0))
    else $error("irq input gating wrong");
  a_tx_next_clk:
    assert property (wr && ix == 2 && pwdata[5:4] == 2'h1 |=>
                     port_c_out[2] == uart_tx && port_c_oe[2] == uart_tx_oe)
    else $error("transmit not routed one clock after write");
  a_gpio_latch:
    assert property (sh[2][1:0] != 2'h1 |-> port_c_out[0] == port_c_latch[0] &&
                     port_c_oe[0] == !port_c_dir_input[0])
    else $error("general pin not driven from latch");
  a_pad_enables:
    assert property (analog_channel_en[1] == (sh[1][5:4] == 2'h1) &&
                     io_supply_pin_en == (sh[1][7:6] == 2'h1))
    else $error("analog or supply enable wrong");
  a_crystal_en:
    assert property (crystal_in_en == (sh[1][3:2] == 2'h2) &&
                     crystal_out_en == (sh[1][1:0] == 2'h1))
    else $error("crystal enable wrong");
  a_reset_gpio:
    assert property ($rose(presetn) |-> port_b_oe == ~port_b_dir_input &&
                     port_c_oe == ~port_c_dir_input)
    else $error("pins not general after reset");

  c_tx_write: cover property (wr && ix == 2);
  c_unmapped: cover property (psel && penable && pslverr);
  c_rx_c5: cover property (sh[4][1:0] == 2'h3);
endmodule

bind pbcfs_top pbcfs_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pslverr, .port_c_latch, .port_c_dir_input, .port_b_dir_input, .port_a_bit0_in,
  .port_b_in, .port_c_in, .uart_tx, .uart_tx_oe, .port_b_oe, .port_c_out,
  .port_c_oe, .external_irq1, .uart_rx_in, .analog_channel_en, .io_supply_pin_en,
  .crystal_in_en, .crystal_out_en
);

// >>> bench/pbcfs_top_test.sv
/* pbcfs_top_test: register and routing checks of pbcfs_top.
   Assumes a 50 MHz clock and an APB slave that may add waits. */
`timescale 1ns/1ps
module pbcfs_top_test
  import pbcfs_pkg::*;
;
  localparam logic [63:0] PB_MODE = 64'h0808A428_1828A424; // per pin, per code
  localparam logic [63:0] PV0     = 64'h0A5B3CA5_FF5AFFC3; // pads as inputs
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, port_b_out, port_b_oe, port_c_out, port_c_oe, r [6];
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [63:0] pv;
  logic [15:0] pat;
  logic        standard_timer1_clock_input, external_irq1, periodic_timer_clock_input;
  logic        periodic_timer_capture_input, low_voltage_detect_input, uart_rx_in;
  logic        opamp1_neg_input_en, io_supply_pin_en, crystal_in_en, crystal_out_en;
  logic [7:1]  analog_channel_en;
  int          error_cnt, num_checks;

  pbcfs_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .port_b_latch(pv[7:0]), .port_b_dir_input(pv[15:8]),
    .port_c_latch(pv[23:16]), .port_c_dir_input(pv[31:24]), .port_b_in(pv[39:32]),
    .port_c_in(pv[47:40]), .port_a_bit0_in(pv[48]), .periodic_timer_output(pv[49]),
    .standard_timer1_output(pv[50]), .opamp1_output(pv[51]), .uart_tx(pv[52]),
    .uart_tx_oe(pv[53]), .uart_halfduplex_out(pv[54]), .uart_halfduplex_oe(pv[55]),
    .lcd_common_drive(pv[59:56]), .lcd_common_oe(pv[63:60]), .port_b_out, .port_b_oe,
    .port_c_out, .port_c_oe, .standard_timer1_clock_input, .external_irq1,
    .periodic_timer_clock_input, .periodic_timer_capture_input,
    .low_voltage_detect_input, .uart_rx_in, .analog_channel_en, .opamp1_neg_input_en,
    .io_supply_pin_en, .crystal_in_en, .crystal_out_en
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g, m);
    num_checks++;
    if (((e ^ g) & m) !== 32'h0) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one APB transfer, waiting on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      error_cnt++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wreg(input int i, input logic [7:0] v, input logic [3:0] s);
    logic [31:0] d;
    logic        e;
    apb(1'h1, 8'(4 * i), {24'h0, v}, s, d, e);
    chk("pslverr", 32'(i > 4), {31'h0, e}, 32'h1);
    if (s[0] && i < 5) r[i] = (i == 4) ? (v & PBCFS_IN_SEL_MASK) : v;
  endtask

  task automatic rreg(input int i);
    logic [31:0] d;
    logic        e;
    apb(1'h0, 8'(4 * i), 32'h0, 4'h0, d, e);
    chk("prdata", {24'h0, r[i]}, d, 32'hFFFFFFFF);
    chk("pslverr", 32'(i > 4), {31'h0, e}, 32'h1);
  endtask

  // routed outputs against a model of the select fields
  task automatic check_pins();
    logic [1:0]  c [8];
    logic [1:0]  m;
    logic [7:0]  dv, co, ce, eo, ee, mo, me;
    dv = {2'h0, pv[49], 1'h0, ~pv[49], 1'h0, ~pv[50], pv[51]};
    co = {pv[59], pv[56], pv[54], pv[52], pv[54], pv[52], pv[57], pv[58]};
    ce = {pv[63], pv[60], pv[55], pv[53], pv[55], pv[53], pv[61], pv[62]};
    eo = pv[7:0];
    ee = ~pv[15:8];
    for (int i = 0; i < 8; i++) begin
      c[i] = r[i / 4][2 * (i % 4) +: 2];
      m = PB_MODE[8 * i + 2 * c[i] +: 2];
      if (m == 2'h1) eo[i] = dv[i];
      if (m == 2'h1) ee[i] = 1'h1;
      if (m == 2'h2) ee[i] = 1'h0;
      mo[i] = (m == 2'h0 || m == 2'h1);
      me[i] = (m != 2'h3);
      if (r[2 + i / 4][2 * (i % 4) +: 2] != 2'h1) co[i] = pv[16 + i];
      if (r[2 + i / 4][2 * (i % 4) +: 2] != 2'h1) ce[i] = ~pv[24 + i];
    end
    chk("port_b_out", 32'(eo), 32'(port_b_out), 32'(mo));
    chk("port_b_oe", 32'(ee), 32'(port_b_oe), 32'(me));
    chk("port_c_out", 32'(co), 32'(port_c_out), 32'hFF);
    chk("port_c_oe", 32'(ce), 32'(port_c_oe), 32'hFF);
    chk("inputs", 32'({c[4] == 1, c[5] == 2, c[7] == 1, c[2] == 1, c[5] == 3, c[4] == 2,
        c[1] == 2, c[3] == 1, c[2] == 2, c[0] == 2, c[6] == 1,
        r[4][1] ? pv[45] : (r[4][0] ? pv[43] : pv[48]), pv[33] & (c[1] == 3),
        pv[37] & (c[5] == 0), pv[38] & (c[6] != 1), pv[33] & (c[1] == 0),
        pv[35] & (c[3] == 0 || c[3] == 3)}),
        32'({crystal_out_en, crystal_in_en, io_supply_pin_en, opamp1_neg_input_en,
        analog_channel_en, uart_rx_in, low_voltage_detect_input,
        periodic_timer_capture_input, periodic_timer_clock_input, external_irq1,
        standard_timer1_clock_input}), 32'h1FFFF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    pv = PV0;
    r = '{default: 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++) rreg(i);
    @(negedge pclk);
    check_pins();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wreg(i, 8'hFF, 4'h1);
      rreg(i);
      wreg(i, 8'h00, 4'h0);
      rreg(i);
      wreg(i, 8'h00, 4'hF);
    end
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      pv <= PV0; // peripherals idle before reselect
      for (int j = 0; j < 4; j++) begin
        pat = 16'hE4E4 >> (2 * ((k + j) % 4));
        wreg(j, pat[7:0], 4'h1);
      end
      wreg(4, 8'hFC | 8'(k), 4'h1);
      for (int p = 0; p < 2; p++) begin
        @(posedge pclk);
        pv <= p ? ~PV0 : PV0;
        @(negedge pclk);
        check_pins();
      end
    end
    $display("test routing done");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    r = '{default: 8'h00};
    for (int i = 0; i < 6; i++) rreg(i);
    @(negedge pclk);
    check_pins();
    $display("test second reset done");
    results();
  end
endmodule
